/* File: rtl/clock_gate_pkg.sv */
// Constants shared by the output gating and reference switchover logic.
// Assumes a single 125 MHz control clock and byte-wide configuration registers.
package clock_gate_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int NUM_BANKS = 6;
    localparam int NUM_PLLS = 3;
    localparam int NUM_GIN = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] ADDR_GIN_ENABLE = 8'h05;
    localparam logic [7:0] ADDR_GATE_CTRL = 8'h1c;
    localparam logic [7:0] ADDR_BANK_SUSPEND = 8'h1d;
    localparam logic [7:0] ADDR_LOOP_SUSPEND = 8'h1e;
    localparam logic [7:0] ADDR_SWITCH_CTRL = 8'h34;
    localparam logic [7:0] ADDR_DISABLE_LO = 8'h60;
    localparam logic [7:0] ADDR_DISABLE_HI = 8'h61;
    localparam logic [7:0] ADDR_STATUS = 8'h62;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int POS_PIN_POLARITY = 7;
    localparam int POS_PIN_FUNCTION = 6;
    localparam int POS_PRIMARY_SEL = 2;
    localparam int POS_SLEEP_GIN = 3;
    localparam int POS_SELECT_GIN = 5;
    localparam logic [1:0] SWITCH_AUTO = 2'h3;
    localparam logic [1:0] DISABLE_UNAFFECTED = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RESET_REG = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLOCK_MHZ = 125;
    localparam int ALIVE_TIMEOUT_NS = 2000;
    localparam int ALIVE_TIMEOUT_CYCLES = (ALIVE_TIMEOUT_NS * CLOCK_MHZ) / 1000;
    localparam int STABLE_PRIMARY_EDGES = 4;
    localparam int SECONDARY_LOSS_EDGES = 2;

endpackage

/* File: rtl/input_activity_monitor.sv */
// Activity monitor for one reference clock input sampled by the control clock.
// Assumes the input toggles well below half the control clock rate.
`timescale 1ns/100ps
`default_nettype none
module input_activity_monitor
    import clock_gate_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = ALIVE_TIMEOUT_CYCLES
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic sample_i,
    output logic edge_o,
    output logic alive_o
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic rise;
        logic alive;
        logic [15:0] idle;
    } mon_state_t;

    mon_state_t st_reg;
    mon_state_t st_next;

    ////////////////////////////////////////////////////////////////////////////
    // Rising edge detect and idle timeout against the control clock
    always_comb begin
        st_next = st_reg;
        st_next.s1 = sample_i;
        st_next.s2 = st_reg.s1;
        st_next.prev = st_reg.s2;
        st_next.rise = st_reg.s2 & ~st_reg.prev;
        if (st_next.rise) begin
            st_next.idle = 16'h0000;
            st_next.alive = 1'b1;
        end else if (st_reg.idle >= 16'(TIMEOUT_CYCLES - 1)) begin
            st_next.alive = 1'b0; // Missing clock timed by counting control clock cycles
        end else begin
            st_next.idle = st_reg.idle + 16'h0001;
        end
    end

    // State register
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign edge_o = st_reg.rise;
    assign alive_o = st_reg.alive;

endmodule
`default_nettype wire

/* File: rtl/output_gating_and_ref_switchover.sv */
// Output bank gating, sleep suspend, lock status and reference switchover.
// Assumes register accesses come from the serial programming engine, one per cycle.
`timescale 1ns/100ps
`default_nettype none
module output_gating_and_ref_switchover
    import clock_gate_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = ALIVE_TIMEOUT_CYCLES
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic gate_pin_i,
    input wire logic [NUM_GIN-1:0] general_inputs_i,
    input wire logic crystal_reference_input_i,
    input wire logic alternate_clock_input_i,
    input wire logic [NUM_PLLS-1:0] pll_locked_i,
    input wire logic [2*NUM_BANKS-1:0] bank_source_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_refused_o,
    output logic [NUM_BANKS-1:0] bank_tristate_o,
    output logic [NUM_BANKS-1:0] bank_power_down_o,
    output logic [NUM_PLLS-1:0] pll_power_down_o,
    output logic [NUM_PLLS-1:0] pll_relock_o,
    output logic shutdown_o,
    output logic osc_stop_o,
    output logic mode_force_manual_o,
    output logic [NUM_GIN-1:0] config_select_o,
    output logic source_is_secondary_o,
    output logic general_output_zero_o,
    output logic general_output_one_o
);

    typedef enum logic {ON_PRIMARY, ON_SECONDARY} sel_state_t;

    typedef struct packed {
        logic [NUM_GIN-1:0] gin_s1, gin_s2;
        logic gate_s1, gate_s2;
        logic [NUM_PLLS-1:0] lock_s1, lock_s2;
        logic [7:0] gin_enable, gate_ctrl, bank_suspend, loop_suspend, switch_ctrl;
        logic [15:0] disable_mode;
        logic boot_done;
        logic [4:0] boot_cfg;
        logic [NUM_BANKS-1:0] tristate, pdown;
        logic [NUM_PLLS-1:0] pll_down, relock;
        logic shutdown, lock_lost, ref_lost, on_secondary;
        sel_state_t sel_state;
        logic [2:0] prim_edges;
        logic [1:0] sec_edges;
        logic [7:0] rdata;
        logic refused;
    } main_state_t;

    main_state_t st_reg;
    main_state_t st_next;

    logic xtal_edge, xtal_alive, alt_edge, alt_alive;

    // Level of a pin after programmable polarity
    function automatic logic pin_asserted(input logic level, input logic active_low);
        pin_asserted = active_low ? ~level : level;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Activity monitors on both reference inputs
    input_activity_monitor #(
        .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
    ) u_mon_xtal (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .sample_i(crystal_reference_input_i),
        .edge_o(xtal_edge),
        .alive_o(xtal_alive)
    );

    input_activity_monitor #(
        .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
    ) u_mon_alt (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .sample_i(alternate_clock_input_i),
        .edge_o(alt_edge),
        .alive_o(alt_alive)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state of the whole block
    always_comb begin
        logic gate_on, sleep_on, sel_pin, prim_sel, auto_mode, prim_edge, sec_edge, prim_alive, prim_lost;
        logic [1:0] src, mode;
        gate_on = 1'b0;
        sleep_on = 1'b0;
        sel_pin = 1'b0;
        prim_sel = 1'b0;
        auto_mode = 1'b0;
        prim_edge = 1'b0;
        sec_edge = 1'b0;
        prim_alive = 1'b0;
        prim_lost = 1'b0;
        src = 2'h0;
        mode = 2'h0;
        st_next = st_reg;
        // Two-stage synchronisers on the pins
        st_next.gin_s1 = general_inputs_i;
        st_next.gin_s2 = st_reg.gin_s1;
        st_next.gate_s1 = gate_pin_i;
        st_next.gate_s2 = st_reg.gate_s1;
        st_next.lock_s1 = pll_locked_i;
        st_next.lock_s2 = st_reg.lock_s1;
        // Power-up capture of configuration inputs, input 5 forced low
        if (!st_reg.boot_done) begin
            st_next.boot_done = 1'b1;
            st_next.boot_cfg = general_inputs_i[4:0];
        end
        // Pin decode
        gate_on = pin_asserted(st_reg.gate_s2, st_reg.gate_ctrl[POS_PIN_POLARITY]);
        st_next.shutdown = gate_on & st_reg.gate_ctrl[POS_PIN_FUNCTION];
        sleep_on = st_reg.gin_s2[POS_SLEEP_GIN] & st_reg.gin_enable[POS_SLEEP_GIN];
        sel_pin = st_reg.gin_s2[POS_SELECT_GIN] & st_reg.gin_enable[POS_SELECT_GIN];
        // PLL suspend; shutdown leaves PLLs running
        for (int p = 0; p < NUM_PLLS; p++) begin
            st_next.pll_down[p] = ~st_next.shutdown & sleep_on & st_reg.loop_suspend[p];
        end
        st_next.relock = st_reg.pll_down & ~st_next.pll_down;
        // Per-bank gating, suspend and shutdown
        for (int b = 0; b < NUM_BANKS; b++) begin
            src = bank_source_i[2*b +: 2];
            mode = st_reg.disable_mode[2*b +: 2];
            st_next.pdown[b] = ~st_next.shutdown & sleep_on & st_reg.bank_suspend[b];
            if (src < 2'(NUM_PLLS)) begin
                if (st_next.pll_down[src]) begin
                    st_next.pdown[b] = 1'b1;
                end
            end
            st_next.tristate[b] = st_next.shutdown | st_next.pdown[b];
            if (~st_reg.gate_ctrl[POS_PIN_FUNCTION] & gate_on & st_reg.gate_ctrl[b]) begin
                if (mode != DISABLE_UNAFFECTED) begin
                    st_next.tristate[b] = 1'b1;
                end
            end
        end
        // Lock status over powered PLLs only
        st_next.lock_lost = |(~st_next.pll_down & ~st_reg.lock_s2);
        // Source roles and loss detection
        prim_sel = st_reg.switch_ctrl[POS_PRIMARY_SEL];
        prim_edge = prim_sel ? alt_edge : xtal_edge;
        sec_edge = prim_sel ? xtal_edge : alt_edge;
        prim_alive = prim_sel ? alt_alive : xtal_alive;
        auto_mode = (st_reg.switch_ctrl[1:0] == SWITCH_AUTO) & ~prim_sel;
        if (prim_edge) begin
            st_next.sec_edges = 2'h0;
        end else if (sec_edge && st_reg.sec_edges != 2'(SECONDARY_LOSS_EDGES)) begin
            st_next.sec_edges = st_reg.sec_edges + 2'h1;
        end
        prim_lost = ~prim_alive | (st_reg.sec_edges == 2'(SECONDARY_LOSS_EDGES));
        // Revertive switchover
        case (st_reg.sel_state)
            ON_PRIMARY: begin
                if (auto_mode && prim_lost) begin
                    st_next.sel_state = ON_SECONDARY;
                    st_next.prim_edges = 3'h0;
                end
            end
            ON_SECONDARY: begin
                if (!auto_mode) begin
                    st_next.sel_state = ON_PRIMARY;
                end else if (prim_lost) begin
                    st_next.prim_edges = 3'h0;
                end else if (prim_edge) begin
                    st_next.prim_edges = st_reg.prim_edges + 3'h1;
                    if (st_reg.prim_edges == 3'(STABLE_PRIMARY_EDGES - 1)) begin
                        st_next.sel_state = ON_PRIMARY;
                    end
                end
            end
            default: begin
                st_next.sel_state = ON_PRIMARY;
            end
        endcase
        if (auto_mode) begin
            st_next.on_secondary = (st_next.sel_state == ON_SECONDARY);
            st_next.ref_lost = st_next.on_secondary | (~xtal_alive & ~alt_alive);
        end else begin
            st_next.on_secondary = sel_pin;
            st_next.ref_lost = ~prim_alive;
        end
        // Register access, refused during shutdown
        st_next.refused = 1'b0;
        if ((reg_wr_i || reg_rd_i) && st_reg.shutdown) begin
            st_next.refused = 1'b1;
        end else if (reg_wr_i) begin
            if (reg_addr_i == ADDR_GIN_ENABLE) begin
                st_next.gin_enable = reg_wdata_i;
            end else if (reg_addr_i == ADDR_GATE_CTRL) begin
                st_next.gate_ctrl = reg_wdata_i;
            end else if (reg_addr_i == ADDR_BANK_SUSPEND) begin
                st_next.bank_suspend = reg_wdata_i;
            end else if (reg_addr_i == ADDR_LOOP_SUSPEND) begin
                st_next.loop_suspend = reg_wdata_i;
            end else if (reg_addr_i == ADDR_SWITCH_CTRL) begin
                st_next.switch_ctrl = reg_wdata_i;
            end else if (reg_addr_i == ADDR_DISABLE_LO) begin
                st_next.disable_mode[7:0] = reg_wdata_i;
            end else if (reg_addr_i == ADDR_DISABLE_HI) begin
                st_next.disable_mode[15:8] = reg_wdata_i;
            end
        end else if (reg_rd_i) begin
            if (reg_addr_i == ADDR_GIN_ENABLE) begin
                st_next.rdata = st_reg.gin_enable;
            end else if (reg_addr_i == ADDR_GATE_CTRL) begin
                st_next.rdata = st_reg.gate_ctrl;
            end else if (reg_addr_i == ADDR_BANK_SUSPEND) begin
                st_next.rdata = st_reg.bank_suspend;
            end else if (reg_addr_i == ADDR_LOOP_SUSPEND) begin
                st_next.rdata = st_reg.loop_suspend;
            end else if (reg_addr_i == ADDR_SWITCH_CTRL) begin
                st_next.rdata = st_reg.switch_ctrl;
            end else if (reg_addr_i == ADDR_DISABLE_LO) begin
                st_next.rdata = st_reg.disable_mode[7:0];
            end else if (reg_addr_i == ADDR_DISABLE_HI) begin
                st_next.rdata = st_reg.disable_mode[15:8];
            end else if (reg_addr_i == ADDR_STATUS) begin
                st_next.rdata = {4'h0, st_reg.on_secondary, st_reg.ref_lost,
                                 st_reg.lock_lost, st_reg.shutdown};
            end else begin
                st_next.rdata = 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; only power-on reset clears the configuration
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata_o = st_reg.rdata;
    assign reg_refused_o = st_reg.refused;
    assign bank_tristate_o = st_reg.tristate;
    assign bank_power_down_o = st_reg.pdown;
    assign pll_power_down_o = st_reg.pll_down;
    assign pll_relock_o = st_reg.relock;
    assign shutdown_o = st_reg.shutdown;
    assign osc_stop_o = st_reg.shutdown;
    assign mode_force_manual_o = st_reg.shutdown;
    assign config_select_o = {1'b0, st_reg.boot_cfg};
    assign source_is_secondary_o = st_reg.on_secondary;
    assign general_output_zero_o = st_reg.lock_lost;
    assign general_output_one_o = st_reg.ref_lost;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    chk_polarity_high: assert property (
        (st_reg.gate_ctrl[7:6] == 2'h1 && st_reg.gate_s2) |=> shutdown_o)
        else $error("Active-high shutdown pin not honoured");
    chk_polarity_low: assert property (
        (st_reg.gate_ctrl[7:6] == 2'h3 && !st_reg.gate_s2 && !reg_wr_i) |=> shutdown_o)
        else $error("Active-low shutdown pin not honoured");
    chk_shutdown_outputs: assert property (
        shutdown_o |-> (&bank_tristate_o && pll_power_down_o == '0 && osc_stop_o && mode_force_manual_o))
        else $error("Shutdown did not tristate banks or stopped a PLL");
    chk_gate_bank_zero: assert property (
        (st_reg.gate_ctrl[7:6] == 2'h0 && st_reg.gate_s2 && st_reg.gate_ctrl[0] &&
         st_reg.disable_mode[1:0] != DISABLE_UNAFFECTED) |=> bank_tristate_o[0])
        else $error("Gated bank 0 not tristated");
    chk_sleep_bank_zero: assert property (
        (!st_next.shutdown && st_reg.gin_s2[3] && st_reg.gin_enable[3] && st_reg.bank_suspend[0])
        |=> bank_power_down_o[0] && bank_tristate_o[0])
        else $error("Suspended bank 0 not powered down");
    chk_loop_suspend: assert property (
        (!st_next.shutdown && st_reg.gin_s2[3] && st_reg.gin_enable[3] && st_reg.loop_suspend[0])
        |=> pll_power_down_o[0])
        else $error("PLL 0 not suspended");
    chk_relock_pulse: assert property (
        $fell(pll_power_down_o[0]) |-> pll_relock_o[0] ##1 !pll_relock_o[0] || $fell(pll_power_down_o[0]))
        else $error("Relock not requested after PLL 0 resumed");
    chk_refuse_write: assert property (
        (shutdown_o && reg_wr_i) |=> reg_refused_o && $stable(st_reg.gate_ctrl))
        else $error("Write accepted during shutdown");
    chk_lock_flag: assert property (
        (!st_reg.lock_s2[0] && !st_next.pll_down[0]) |=> general_output_zero_o)
        else $error("Lock loss of PLL 0 not flagged");
    chk_manual_select: assert property (
        (st_reg.switch_ctrl[1:0] != SWITCH_AUTO && st_reg.gin_s2[5] && st_reg.gin_enable[5])
        |=> source_is_secondary_o)
        else $error("Manual select pin ignored");
    chk_boot_latch: assert property (
        $rose(st_reg.boot_done) |-> config_select_o == {1'b0, $past(general_inputs_i[4:0])})
        else $error("Power-up configuration not latched");

    cov_shutdown: cover property ($rose(shutdown_o));
    cov_auto_switch: cover property ($rose(source_is_secondary_o) && st_reg.switch_ctrl[1:0] == SWITCH_AUTO);
    cov_auto_revert: cover property ($fell(source_is_secondary_o) && st_reg.switch_ctrl[1:0] == SWITCH_AUTO);
    cov_relock: cover property (|pll_relock_o);

endmodule
`default_nettype wire

/* File: verif/board_partner.sv */
// Board-side model: drives the gate pin and both reference clock inputs.
// Assumes the bench changes its commands just after rising edges of clock_i.
`timescale 1ns/100ps
`default_nettype none
module board_partner (
    input wire logic clock_i,
    input wire logic gate_on_i,
    input wire logic active_low_i,
    input wire logic xtal_run_i,
    input wire logic alt_run_i,
    output logic gate_pin_o,
    output logic xtal_o,
    output logic alt_o
);
    logic [1:0] div_reg = 2'h0;
    logic xtal_reg = 1'b0;
    logic alt_reg = 1'b0;
    // Pin held at its asserted level while requested, released before programming
    assign gate_pin_o = gate_on_i ^ active_low_i;
    assign xtal_o = xtal_reg;
    assign alt_o = alt_reg;
    // Both clocks share one period of six cycles; a stopped clock stays frozen
    always @(posedge clock_i) begin
        div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
        if (div_reg == 2'h2) begin
            xtal_reg <= xtal_reg ^ xtal_run_i;
            alt_reg <= alt_reg ^ alt_run_i;
        end
    end
endmodule
`default_nettype wire

/* File: verif/output_gating_and_ref_switchover_tb.sv */
// Self-checking bench for the output gating and reference switchover block.
// Assumes the board partner model supplies the gate pin and reference clocks.
`timescale 1ns/100ps
`default_nettype none
module output_gating_and_ref_switchover_tb;
    import clock_gate_pkg::*;
    localparam int TMO = 16;
    typedef struct packed {logic [7:0] g, d, s, l, e; logic pin, slp; logic [2:0] lk;
        logic [5:0] tri_e, pd_e; logic [2:0] ppd_e; logic sd_e, lk_e;} row_t;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic gate_on = 1'b0, act_low = 1'b0, xrun = 1'b1, arun = 1'b1, wr = 1'b0, rd = 1'b0;
    logic gate_pin, xtal, alt, refused, sd, osc, man, sec, lk_lost, ref_lost;
    logic [5:0] gin = 6'h2a;
    logic [2:0] lock = 3'h7;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
    logic [5:0] bank_tri, pd, cfg;
    logic [2:0] ppd, relock;
    int err_total = 0, num_checks = 0, n, nref = 0, nrel = 0;
    row_t rows [10] = '{
        '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 1'h1, 1'h0, 3'h7, 6'h03, 6'h00, 3'h0, 1'h0, 1'h0},
        '{8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 1'h1, 1'h0, 3'h7, 6'h3f, 6'h00, 3'h0, 1'h1, 1'h0},
        '{8'h83, 8'h00, 8'h00, 8'h00, 8'h00, 1'h0, 1'h0, 3'h7, 6'h00, 6'h00, 3'h0, 1'h0, 1'h0},
        '{8'h83, 8'h00, 8'h00, 8'h00, 8'h00, 1'h1, 1'h0, 3'h7, 6'h03, 6'h00, 3'h0, 1'h0, 1'h0},
        '{8'h40, 8'h00, 8'h30, 8'h01, 8'h08, 1'h1, 1'h1, 3'h7, 6'h3f, 6'h00, 3'h0, 1'h1, 1'h0},
        '{8'h00, 8'h00, 8'h31, 8'h00, 8'h08, 1'h0, 1'h1, 3'h7, 6'h31, 6'h31, 3'h0, 1'h0, 1'h0},
        '{8'h00, 8'h00, 8'h30, 8'h01, 8'h08, 1'h0, 1'h1, 3'h6, 6'h33, 6'h33, 3'h1, 1'h0, 1'h0},
        '{8'h00, 8'h00, 8'h30, 8'h01, 8'h00, 1'h0, 1'h1, 3'h7, 6'h00, 6'h00, 3'h0, 1'h0, 1'h0},
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'h0, 1'h0, 3'h6, 6'h00, 6'h00, 3'h0, 1'h0, 1'h1},
        '{8'h03, 8'h02, 8'h10, 8'h01, 8'h08, 1'h1, 1'h0, 3'h7, 6'h02, 6'h00, 3'h0, 1'h0, 1'h0}};

    ////////////////////////////////////////////////////////////////////////////
    output_gating_and_ref_switchover #(.TIMEOUT_CYCLES(TMO)) u_output_gating_and_ref_switchover (
        .clock_i(clock_i), .resetn_i(resetn_i), .gate_pin_i(gate_pin), .general_inputs_i(gin),
        .crystal_reference_input_i(xtal), .alternate_clock_input_i(alt), .pll_locked_i(lock),
        .bank_source_i(12'hf90), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_refused_o(refused), .bank_tristate_o(bank_tri),
        .bank_power_down_o(pd), .pll_power_down_o(ppd), .pll_relock_o(relock), .shutdown_o(sd),
        .osc_stop_o(osc), .mode_force_manual_o(man), .config_select_o(cfg),
        .source_is_secondary_o(sec), .general_output_zero_o(lk_lost), .general_output_one_o(ref_lost));
    board_partner u_board_partner (.clock_i(clock_i), .gate_on_i(gate_on), .active_low_i(act_low),
        .xtal_run_i(xrun), .alt_run_i(arun), .gate_pin_o(gate_pin), .xtal_o(xtal), .alt_o(alt));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, pulse counters and watchdog
    initial begin
        forever #4 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        nref <= nref + int'(refused === 1'b1);
        nrel <= nrel + int'(relock[0] === 1'b1);
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        err_total++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register accesses, comparison and verdict
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        @(posedge clock_i);
        @(negedge clock_i);
        v = rdata;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge clock_i);
        @(negedge clock_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, table rows, then hand-written cases
    initial begin
        repeat (5) @(posedge clock_i);
        resetn_i <= 1'b1;
        settle(1);
        chk("config select", 8'h0a, {2'h0, cfg});
        rd_reg(ADDR_SWITCH_CTRL, d);
        chk("reset value", 8'h00, d);
        rd_reg(8'h07, d);
        chk("unmapped read", 8'h00, d);
        // Table rows: gate pin gating and shutdown, bank suspend, loop suspend, input enables and lock status
        foreach (rows[i]) begin
            @(posedge clock_i);
            gate_on <= 1'b0;
            act_low <= rows[i].g[7];
            gin <= 6'h00;
            lock <= rows[i].lk;
            repeat (4) @(posedge clock_i);
            wr_reg(ADDR_DISABLE_LO, rows[i].d);
            wr_reg(ADDR_BANK_SUSPEND, rows[i].s);
            wr_reg(ADDR_LOOP_SUSPEND, rows[i].l);
            wr_reg(ADDR_GIN_ENABLE, rows[i].e);
            wr_reg(ADDR_GATE_CTRL, rows[i].g);
            gate_on <= rows[i].pin;
            gin <= {2'h0, rows[i].slp, 3'h0};
            settle(6);
            chk("tristate", {2'h0, rows[i].tri_e}, {2'h0, bank_tri});
            chk("power down", {2'h0, rows[i].pd_e}, {2'h0, pd});
            chk("status", {1'h0, rows[i].ppd_e, {3{rows[i].sd_e}}, rows[i].lk_e},
                {1'h0, ppd, sd, osc, man, lk_lost});
        end
        // PLL0 leaves suspend and must pulse for relock once
        @(posedge clock_i);
        gin <= 6'h08;
        repeat (6) @(posedge clock_i);
        n = nrel;
        gin <= 6'h00;
        settle(8);
        chk("relock", 8'h01, 8'(nrel - n));
        // Shutdown refuses a write and keeps the stored value
        wr_reg(ADDR_GATE_CTRL, 8'h40);
        repeat (5) @(posedge clock_i);
        n = nref;
        wr_reg(ADDR_BANK_SUSPEND, 8'hff);
        settle(3);
        chk("refused", 8'h01, 8'(nref - n));
        @(posedge clock_i);
        gate_on <= 1'b0;
        repeat (5) @(posedge clock_i);
        rd_reg(ADDR_BANK_SUSPEND, d);
        chk("retained", 8'h10, d);
        // Automatic revertive switchover with crystal primary
        wr_reg(ADDR_SWITCH_CTRL, 8'h03);
        xrun <= 1'b0;
        settle(40);
        chk("primary lost", 8'h03, {6'h0, sec, ref_lost});
        rd_reg(ADDR_STATUS, d);
        chk("status register", 8'h0c, d);
        @(posedge clock_i);
        xrun <= 1'b1;
        settle(80);
        chk("reverted", 8'h00, {6'h0, sec, ref_lost});
        // Manual selection by the select pin, then alternate primary without auto
        wr_reg(ADDR_GIN_ENABLE, 8'h20);
        wr_reg(ADDR_SWITCH_CTRL, 8'h00);
        gin <= 6'h20;
        settle(6);
        chk("manual", 8'h02, {6'h0, sec, ref_lost});
        wr_reg(ADDR_SWITCH_CTRL, 8'h07);
        gin <= 6'h00;
        xrun <= 1'b0;
        settle(40);
        chk("alternate primary", 8'h00, {6'h0, sec, ref_lost});
        summarize();
    end
endmodule
`default_nettype wire
